/* File: design/xae_exec.sv */
/*
 Execution datapath for the exclusive-OR of the working accumulator with a
 data-file register. Holds the accumulator and the zero flag; the file is
 outside and answers a read address combinationally in the same cycle.
*/
// Summary of operation
// - Result is accumulator XOR the addressed file register.
// - Destination bit clear: result to accumulator, file untouched.
// - Destination bit set: result to file register, accumulator untouched.
// - Opcode is upper seven bits 0000110, bit 8 destination, low byte address.
// - Decode in quarter one, read two, compute three, write four.
`timescale 1ns/1ps
`default_nettype none
module xae_exec #(
    parameter int DATA_W = xae_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Instruction, sampled in the decode quarter
    input  wire logic [15:0]       instr_word,
    // Data file read data for file_addr
    input  wire logic [DATA_W-1:0] file_rd_data,
    // Data file access
    output logic [7:0]             file_addr,
    output logic [DATA_W-1:0]      file_wr_data,
    output logic                   file_wr_en,
    // Core state
    output logic [DATA_W-1:0]      working_accumulator,
    output logic                   zero_flag,
    output logic                   op_done
);
    xae_pkg::xae_phase_type phase;
    logic                   op_active;
    logic                   dest_file;
    logic [DATA_W-1:0]      operand;
    logic [DATA_W-1:0]      result;

    xae_phase_gen u_phase (
        .clock (clock),
        .rst_n (rst_n),
        .phase (phase)
    );

    // ========================================
    // Decode
    wire        in_q1      = (phase == xae_pkg::XAE_Q1_DECODE);
    wire        in_q2      = (phase == xae_pkg::XAE_Q2_READ);
    wire        in_q3      = (phase == xae_pkg::XAE_Q3_PROCESS);
    wire        in_q4      = (phase == xae_pkg::XAE_Q4_WRITE);
    wire        is_xor_op  = (instr_word[xae_pkg::OPC_MSB:xae_pkg::OPC_LSB] == xae_pkg::OPC_XOR_FILE);
    wire [DATA_W-1:0] next_result = working_accumulator ^ operand;
    wire        write_acc  = in_q4 && op_active && !dest_file;
    wire        write_file = in_q4 && op_active && dest_file;

    // ========================================
    // Decode quarter latches the fields
    // Fields held all instruction long; the file address must not move
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            op_active <= 1'b0;
            dest_file <= 1'b0;
            file_addr <= 8'h00;
        end else if (in_q1) begin
            op_active <= is_xor_op;
            dest_file <= instr_word[xae_pkg::DEST_BIT];
            file_addr <= instr_word[xae_pkg::ADDR_MSB:xae_pkg::ADDR_LSB];
        end
    end

    // ========================================
    // Read in Q2, process in Q3
    // Operand kept in a register so the file may change after Q2
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            operand <= '0;
            result  <= '0;
        end else begin
            if (in_q2) operand <= file_rd_data;
            if (in_q3) result <= next_result;
        end
    end

    // ========================================
    // Write quarter; outputs registered so file strobe is one cycle
    // Zero flag follows both destinations; no other flag lives here
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            working_accumulator <= xae_pkg::ACC_RESET;
            zero_flag           <= xae_pkg::ZERO_RESET;
            file_wr_data        <= '0;
            file_wr_en          <= 1'b0;
            op_done             <= 1'b0;
        end else begin
            file_wr_en <= 1'b0;
            op_done    <= in_q4 && op_active;
            if (write_acc) working_accumulator <= result;
            if (write_file) begin
                file_wr_data <= result;
                file_wr_en   <= 1'b1;
            end
            if (in_q4 && op_active) zero_flag <= (result == '0);
        end
    end

    // ========================================
    // Checks
    property p_acc_update;
        @(posedge clock) disable iff (!rst_n)
        write_acc |=> (working_accumulator == $past(result));
    endproperty
    a_acc_update: assert property (p_acc_update) else $error("accumulator not written");

    property p_file_keeps_acc;
        @(posedge clock) disable iff (!rst_n)
        write_file |=> file_wr_en && $stable(working_accumulator) && file_wr_data == $past(result);
    endproperty
    a_file_keeps_acc: assert property (p_file_keeps_acc) else $error("file write wrong");

    property p_xor;
        @(posedge clock) disable iff (!rst_n)
        in_q3 |=> result == ($past(working_accumulator) ^ $past(operand));
    endproperty
    a_xor: assert property (p_xor) else $error("xor result wrong");

    property p_zero;
        @(posedge clock) disable iff (!rst_n)
        (in_q4 && op_active) |=> zero_flag == ($past(result) == '0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_no_op_no_change;
        @(posedge clock) disable iff (!rst_n)
        !op_active && in_q4 |=> $stable(zero_flag) && !file_wr_en;
    endproperty
    a_no_op_no_change: assert property (p_no_op_no_change) else $error("idle changed state");

    sequence s_decode;
        in_q1 && is_xor_op;
    endsequence
    property p_phase_order;
        @(posedge clock) disable iff (!rst_n)
        s_decode |=> in_q2 ##1 in_q3 ##1 in_q4 ##1 op_done;
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("quarter order wrong");

    property p_decode_fields;
        @(posedge clock) disable iff (!rst_n)
        in_q1 |=> file_addr == $past(instr_word[7:0]) && op_active == $past(is_xor_op);
    endproperty
    a_decode_fields: assert property (p_decode_fields) else $error("decode wrong");

    property p_dest_zero;
        @(posedge clock) disable iff (!rst_n)
        write_acc |=> !file_wr_en;
    endproperty
    a_dest_zero: assert property (p_dest_zero) else $error("file written on acc dest");

    // ========================================
    // Strobes and holds
    property p_wr_en_pulse;
        @(posedge clock) disable iff (!rst_n)
        file_wr_en |=> !file_wr_en;
    endproperty
    a_wr_en_pulse: assert property (p_wr_en_pulse) else $error("file strobe too long");

    property p_op_done_pulse;
        @(posedge clock) disable iff (!rst_n)
        op_done |=> !op_done;
    endproperty
    a_op_done_pulse: assert property (p_op_done_pulse) else $error("done strobe too long");

    property p_addr_hold;
        @(posedge clock) disable iff (!rst_n)
        !in_q1 |=> $stable(file_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("file address moved mid-instruction");

    property p_dest_latched;
        @(posedge clock) disable iff (!rst_n)
        in_q1 |=> dest_file == $past(instr_word[xae_pkg::DEST_BIT]);
    endproperty
    a_dest_latched: assert property (p_dest_latched) else $error("destination bit not latched");

    property p_operand_read;
        @(posedge clock) disable iff (!rst_n)
        in_q2 |=> operand == $past(file_rd_data);
    endproperty
    a_operand_read: assert property (p_operand_read) else $error("operand not read in quarter two");

    // ========================================
    // Refused words and flag scope
    property p_refuse_keeps_acc;
        @(posedge clock) disable iff (!rst_n)
        (in_q4 && !op_active) |=> $stable(working_accumulator);
    endproperty
    a_refuse_keeps_acc: assert property (p_refuse_keeps_acc) else $error("refused word changed accumulator");

    property p_zero_only_q4;
        @(posedge clock) disable iff (!rst_n)
        !(in_q4 && op_active) |=> $stable(zero_flag);
    endproperty
    a_zero_only_q4: assert property (p_zero_only_q4) else $error("zero flag moved outside write");

    // ========================================
    // Whole instruction, decode to write
    // Four quarters are fixed, so the write lands exactly four edges on
    sequence s_decode_to_acc;
        in_q1 && is_xor_op && !instr_word[xae_pkg::DEST_BIT];
    endsequence
    sequence s_decode_to_file;
        in_q1 && is_xor_op && instr_word[xae_pkg::DEST_BIT];
    endsequence
    property p_acc_dest_slot;
        @(posedge clock) disable iff (!rst_n)
        s_decode_to_acc |-> ##4 (op_done && !file_wr_en);
    endproperty
    a_acc_dest_slot: assert property (p_acc_dest_slot) else $error("accumulator op wrote the file");

    property p_file_dest_slot;
        @(posedge clock) disable iff (!rst_n)
        s_decode_to_file |-> ##4 (op_done && file_wr_en);
    endproperty
    a_file_dest_slot: assert property (p_file_dest_slot) else $error("file op did not write the file");
endmodule
`default_nettype wire

/* File: design/xae_phase_gen.sv */
/*
 Quarter-phase sequencer: steps decode, read, process, write in turn.
 Assumes a synchronous active-low reset; one phase per clock.
*/
`timescale 1ns/1ps
`default_nettype none
module xae_phase_gen (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // Phase out
    output var  xae_pkg::xae_phase_type phase
);
    // ========================================
    // Free-running four-state cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase <= xae_pkg::XAE_Q1_DECODE;
        end else begin
            unique case (phase)
                xae_pkg::XAE_Q1_DECODE:  phase <= xae_pkg::XAE_Q2_READ;
                xae_pkg::XAE_Q2_READ:    phase <= xae_pkg::XAE_Q3_PROCESS;
                xae_pkg::XAE_Q3_PROCESS: phase <= xae_pkg::XAE_Q4_WRITE;
                xae_pkg::XAE_Q4_WRITE:   phase <= xae_pkg::XAE_Q1_DECODE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: pkg/xae_pkg.sv */
/*
 Package for the exclusive-OR execution datapath: opcode fields, phase
 enumeration and reset values. Assumes one 125 MHz core clock.
*/
`default_nettype none
package xae_pkg;
    // ========================================
    // Instruction word layout
    localparam int          INSTR_W      = 16;
    localparam int          DATA_W       = 8;
    localparam int          OPC_MSB      = 15;
    localparam int          OPC_LSB      = 9;
    localparam logic [6:0]  OPC_XOR_FILE = 7'h06;
    localparam int          DEST_BIT     = 8;
    localparam int          ADDR_MSB     = 7;
    localparam int          ADDR_LSB     = 0;
    // ========================================
    // Reset values
    localparam logic [7:0]  ACC_RESET    = 8'h00;
    localparam logic        ZERO_RESET   = 1'b0;
    // ========================================
    // Quarter phases
    typedef enum logic [1:0] {
        XAE_Q1_DECODE,
        XAE_Q2_READ,
        XAE_Q3_PROCESS,
        XAE_Q4_WRITE
    } xae_phase_type;
endpackage
`default_nettype wire

/* File: sim/xor_acc_file_exec_bench.sv */
/*
 Self-checking bench for xae_exec: xor result, destination and zero flag.
 Assumes the data file reads combinationally; the bench models it here.
*/
`timescale 1ns/1ps
`default_nettype none
module xor_acc_file_exec_bench;
    // ========================================
    // Signals and file model
    logic        clock        = 1'b0;
    logic        rst_n        = 1'b0;
    logic [15:0] instr_word   = 16'h0000;
    logic [7:0]  file_rd_data;
    logic [7:0]  file_addr;
    logic [7:0]  file_wr_data;
    logic [7:0]  working_accumulator;
    logic        file_wr_en;
    logic        zero_flag;
    logic        op_done;
    logic [7:0]  mem [256];
    logic [7:0]  acc_m        = 8'h00;
    logic        zero_m       = 1'b0;
    int          n_mismatch   = 0;
    int          checks_done  = 0;
    int          cyc          = 0;

    always #4 clock = ~clock;
    assign file_rd_data = mem[file_addr];

    xae_exec DUT (
        .clock               (clock),
        .rst_n               (rst_n),
        .instr_word          (instr_word),
        .file_rd_data        (file_rd_data),
        .file_addr           (file_addr),
        .file_wr_data        (file_wr_data),
        .file_wr_en          (file_wr_en),
        .working_accumulator (working_accumulator),
        .zero_flag           (zero_flag),
        .op_done             (op_done)
    );

    // ========================================
    // Shared tasks
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One instruction slot plus one idle slot, so results are seen alone
    task automatic do_op(input logic [15:0] w);
        logic [7:0] r;
        logic       hit;
        hit = (w[15:9] === xae_pkg::OPC_XOR_FILE);
        r = acc_m ^ mem[w[7:0]];
        instr_word = w;
        repeat (2) @(negedge clock);
        if (hit) chk("file_addr", {8'h00, file_addr}, {8'h00, w[7:0]});
        repeat (2) @(negedge clock);
        instr_word = 16'h0000;
        if (hit) begin
            zero_m = (r == 8'h00);
            if (w[8]) mem[w[7:0]] = r;
            else acc_m = r;
        end
        chk("op_done", {15'h0000, op_done}, {15'h0000, hit});
        chk("file_wr_en", {15'h0000, file_wr_en}, {15'h0000, hit & w[8]});
        if (hit & w[8]) chk("file_wr_data", {8'h00, file_wr_data}, {8'h00, r});
        chk("accumulator", {8'h00, working_accumulator}, {8'h00, acc_m});
        chk("zero_flag", {15'h0000, zero_flag}, {15'h0000, zero_m});
        @(negedge clock);
        chk("op_done pulse", {15'h0000, op_done}, 16'h0000);
        chk("file_wr_en pulse", {15'h0000, file_wr_en}, 16'h0000);
        repeat (3) @(negedge clock);
    endtask

    // ========================================
    // Scenarios
    // Start-up reset, and again mid-run with state to clear
    task automatic t_reset;
        rst_n  = 1'b0;
        acc_m  = xae_pkg::ACC_RESET;
        zero_m = xae_pkg::ZERO_RESET;
        repeat (2) @(negedge clock);
        chk("reset acc", {8'h00, working_accumulator}, {8'h00, xae_pkg::ACC_RESET});
        chk("reset op_done", {15'h0000, op_done}, 16'h0000);
        chk("reset zero", {15'h0000, zero_flag}, {15'h0000, xae_pkg::ZERO_RESET});
        rst_n = 1'b1;
    endtask

    // Accumulator load, then result written back to the file
    task automatic t_dest;
        do_op(16'h0C40);
        do_op(16'h0D25);
    endtask

    // Zero result sets the flag; next non-zero result clears it
    task automatic t_zero;
        do_op(16'h0C40);
        do_op(16'h0C25);
    endtask

    // Words with other opcodes must change nothing
    task automatic t_refuse;
        logic [15:0] bad [3];
        bad = '{16'h0F40, 16'h8C40, 16'h0E25};
        // File byte 5A reads zero, so the flag is set before the refusals
        do_op(16'h0C5A);
        foreach (bad[i]) do_op(bad[i]);
    endtask

    task automatic final_report;
        $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        foreach (mem[i]) mem[i] = i[7:0] ^ 8'h5A;
        mem[8'h25] = 8'hAF;
        mem[8'h40] = 8'hB5;
        t_reset();
        t_dest();
        t_zero();
        t_reset();
        t_refuse();
        final_report();
    end
endmodule
`default_nettype wire
